//--- src/rmap_port.sv
// ROM, serial ROM and management access port with an AHB-Lite slave
//
// Behaviour
// - Load-done status bit 21 after autoload
// - Bit 20 requests a serial ROM reload
// - Bit 19 reads management data pin
// - Bit 18 sets management data direction
// - Bit 17 drives management data pin
// - Bit 16 drives management clock pin
// - Bit 14 starts a memory read
// - Bit 13 starts a memory write
// - Bit 12 routes accesses to boot ROM
// - Bit 11 routes accesses to serial ROM
// - Bit 10 selects the external register
// - Low byte holds boot ROM data
// - Bit 3 reflects serial ROM input pin
// - Bit 2 drives serial ROM data out
// - Bit 1 drives serial ROM clock
// - Bit 0 drives serial ROM select
// - Pointer register holds 18-bit ROM address
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module rmap_port import rmap_pkg::*; #(
    parameter int LOAD_WORDS = 8
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Interrupt
    output logic o_irq,
    // Serial ROM pins
    input wire logic i_serial_rom_in_pin,
    output rmap_srom_t o_srom,
    // Management pins
    input wire logic i_mgmt_data_pin,
    output rmap_mgmt_t o_mgmt,
    // Boot ROM bus
    input wire logic [7:0] i_rom_data,
    output rmap_rom_t o_rom,
    // Configuration words loaded from the serial ROM
    output logic o_cfg_we,
    output logic [RMAP_SR_ADDR_W-1:0] o_cfg_addr,
    output logic [15:0] o_cfg_data
);

    if (LOAD_WORDS < 1 || LOAD_WORDS > (1 << RMAP_SR_ADDR_W)) begin : g_bad_n
        $error("LOAD_WORDS out of range");
    end
    if (RMAP_ROM_ACC_CYC < 3) begin : g_bad_acc
        $error("ROM strobe shorter than input synchroniser");
    end

    typedef enum logic [1:0] {
        AL_IDLE = 2'b00,
        AL_SHIFT = 2'b01,
        AL_GAP = 2'b11
    } rmap_al_t;

    typedef enum logic [1:0] {
        MA_IDLE = 2'b00,
        MA_READ = 2'b01,
        MA_WRITE = 2'b10
    } rmap_ma_t;

    // Control fields of the access register, then the pointer and interrupt registers
    logic load_done;
    logic reload_req;
    logic boot_load;
    logic md_dir;
    logic md_out;
    logic md_clk;
    logic rd_trig;
    logic wr_trig;
    logic brom_sel;
    logic srom_sel;
    logic xreg_sel;
    logic [7:0] data;
    logic [RMAP_PTR_W-1:0] pointer;
    logic [RMAP_EV_W-1:0] irq_stat;
    logic [RMAP_EV_W-1:0] irq_mask;
    // Bus
    logic dph;
    logic dph_write;
    logic [7:0] dph_addr;
    // Synchronisers
    logic [1:0] sr_in_sync;
    logic [1:0] md_in_sync;
    logic [7:0] rom_sync1;
    logic [7:0] rom_sync2;
    // Autoload engine
    rmap_al_t al_state;
    logic [7:0] al_cnt;
    logic al_sk;
    logic al_cs;
    logic [4:0] al_bit;
    logic [RMAP_SR_ADDR_W-1:0] al_word;
    logic [RMAP_SR_CMD_BITS-1:0] al_cmd;
    logic [15:0] al_shift;
    logic ev_load;
    // Memory access engine
    rmap_ma_t ma_state;
    logic [7:0] ma_cnt;
    logic ev_rd;
    logic ev_wr;

    logic bus_wr;
    logic al_tick;
    logic al_start;
    logic [RMAP_EV_W-1:0] events;
    logic [RMAP_EV_W-1:0] next_irq_stat;

    // Serial ROM read frame for one word address
    function automatic logic [RMAP_SR_CMD_BITS-1:0] sr_cmd(
        input logic [RMAP_SR_ADDR_W-1:0] addr
    );
        sr_cmd = {RMAP_SR_READ_OP, addr};
    endfunction

    // Write into a register at a given offset in this data phase
    function automatic logic hit(input logic [7:0] ofs);
        hit = bus_wr && (dph_addr == ofs);
    endfunction

    assign bus_wr = dph && !o_hreadyout && dph_write;
    assign al_tick = (al_cnt == 8'h00);
    assign al_start = (al_state == AL_IDLE) && (reload_req || boot_load);
    assign events = {ev_wr, ev_rd, ev_load};

    // Two flip-flops on every pin input before any logic reads it
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sr_in_sync <= 2'h0;
            md_in_sync <= 2'h0;
            rom_sync1 <= 8'h00;
            rom_sync2 <= 8'h00;
        end else begin
            sr_in_sync <= {sr_in_sync[0], i_serial_rom_in_pin};
            md_in_sync <= {md_in_sync[0], i_mgmt_data_pin};
            rom_sync1 <= i_rom_data;
            rom_sync2 <= rom_sync1;
        end
    end

    // Every transfer takes one wait state, so reads see earlier writes
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dph <= 1'b0;
            dph_write <= 1'b0;
            dph_addr <= 8'h00;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else if (dph && !o_hreadyout) begin
            dph <= 1'b0;
            o_hreadyout <= 1'b1;
        end else if (i_hsel && i_htrans[1] && i_hready) begin
            dph <= 1'b1;
            dph_write <= i_hwrite;
            dph_addr <= {i_haddr[7:2], 2'b00};
            o_hreadyout <= 1'b0;
        end
    end

    // Read data is registered at the end of the wait state
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hrdata <= 32'h0000_0000;
        end else if (dph && !o_hreadyout && !dph_write) begin
            unique case (dph_addr)
                RMAP_OFS_ACCESS: begin
                    o_hrdata <= '0;
                    o_hrdata[RMAP_B_LOAD_DONE] <= load_done;
                    o_hrdata[RMAP_B_RELOAD] <= reload_req;
                    o_hrdata[RMAP_B_MD_IN] <= md_in_sync[1];
                    o_hrdata[RMAP_B_MD_DIR] <= md_dir;
                    o_hrdata[RMAP_B_MD_OUT] <= md_out;
                    o_hrdata[RMAP_B_MD_CLK] <= md_clk;
                    o_hrdata[RMAP_B_ONE_HI] <= 1'b1;
                    o_hrdata[RMAP_B_RD_TRIG] <= rd_trig;
                    o_hrdata[RMAP_B_WR_TRIG] <= wr_trig;
                    o_hrdata[RMAP_B_BROM_SEL] <= brom_sel;
                    o_hrdata[RMAP_B_SROM_SEL] <= srom_sel;
                    o_hrdata[RMAP_B_XREG_SEL] <= xreg_sel;
                    o_hrdata[RMAP_B_ONE_LO+1 -: 2] <= 2'h3;
                    o_hrdata[7:0] <= data;
                    if (srom_sel)
                        o_hrdata[RMAP_B_SR_RET] <= sr_in_sync[1];
                end
                RMAP_OFS_POINTER: o_hrdata <= {14'h0000, pointer};
                RMAP_OFS_IRQ_STAT: o_hrdata <= {29'h0000_0000, irq_stat};
                RMAP_OFS_IRQ_MASK: o_hrdata <= {29'h0000_0000, irq_mask};
                default: o_hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Access register control fields; software write wins over hardware clear
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reload_req <= 1'b0;
            md_dir <= 1'b0;
            md_out <= 1'b0;
            md_clk <= 1'b0;
            rd_trig <= 1'b0;
            wr_trig <= 1'b0;
            brom_sel <= RMAP_RST_BROM_SEL;
            srom_sel <= RMAP_RST_SROM_SEL;
            xreg_sel <= RMAP_RST_XREG_SEL;
        end else begin
            if (al_start)
                reload_req <= 1'b0;
            if (ev_rd)
                rd_trig <= 1'b0;
            if (ev_wr)
                wr_trig <= 1'b0;
            if (hit(RMAP_OFS_ACCESS)) begin
                if (i_hwdata[RMAP_B_RELOAD])
                    reload_req <= 1'b1;
                md_dir <= i_hwdata[RMAP_B_MD_DIR];
                md_out <= i_hwdata[RMAP_B_MD_OUT];
                md_clk <= i_hwdata[RMAP_B_MD_CLK];
                if (ma_state == MA_IDLE) begin
                    rd_trig <= i_hwdata[RMAP_B_RD_TRIG];
                    wr_trig <= i_hwdata[RMAP_B_WR_TRIG];
                end
                brom_sel <= i_hwdata[RMAP_B_BROM_SEL];
                srom_sel <= i_hwdata[RMAP_B_SROM_SEL];
                xreg_sel <= i_hwdata[RMAP_B_XREG_SEL];
            end
        end
    end

    // Data byte: written by software, loaded by a finished ROM read
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data <= RMAP_RST_DATA;
        end else if (ma_state == MA_READ && ma_cnt == 8'h00) begin
            data <= rom_sync2;
        end else if (hit(RMAP_OFS_ACCESS)) begin
            data <= i_hwdata[7:0];
        end
    end

    // Pointer has no reset value; software must load it before use
    always_ff @(posedge i_mclk) begin
        if (hit(RMAP_OFS_POINTER))
            pointer <= i_hwdata[RMAP_PTR_W-1:0];
    end

    // Sticky interrupt status, write one to clear, events win
    always_comb begin
        next_irq_stat = irq_stat;
        if (hit(RMAP_OFS_IRQ_STAT))
            next_irq_stat = irq_stat & ~i_hwdata[RMAP_EV_W-1:0];
        next_irq_stat = next_irq_stat | events;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_stat <= '0;
            irq_mask <= '0;
            o_irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            if (hit(RMAP_OFS_IRQ_MASK))
                irq_mask <= i_hwdata[RMAP_EV_W-1:0];
            o_irq <= |(next_irq_stat & irq_mask);
        end
    end

    // Autoload engine: runs once after reset and on each reload request
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            al_state <= AL_IDLE;
            al_cnt <= 8'h00;
            al_sk <= 1'b0;
            al_cs <= 1'b0;
            al_bit <= 5'h00;
            al_word <= '0;
            al_cmd <= '0;
            al_shift <= 16'h0000;
            boot_load <= 1'b1;
            load_done <= 1'b0;
            ev_load <= 1'b0;
            o_cfg_we <= 1'b0;
            o_cfg_addr <= '0;
            o_cfg_data <= 16'h0000;
        end else begin
            ev_load <= 1'b0;
            o_cfg_we <= 1'b0;
            al_cnt <= al_tick ? 8'(RMAP_SR_HALF_CYC - 1) : al_cnt - 8'h01;
            unique case (al_state)
                AL_IDLE: begin
                    if (al_start) begin
                        al_state <= AL_SHIFT;
                        boot_load <= 1'b0;
                        load_done <= 1'b0;
                        al_word <= '0;
                        al_bit <= 5'h00;
                        al_sk <= 1'b0;
                        al_cs <= 1'b1;
                        al_cmd <= sr_cmd('0);
                        al_cnt <= 8'(RMAP_SR_HALF_CYC - 1);
                    end
                end
                AL_SHIFT: begin
                    if (al_tick && !al_sk) begin
                        // Rising clock: the ROM data bit is stable now
                        al_sk <= 1'b1;
                        if (al_bit >= 5'(RMAP_SR_CMD_BITS))
                            al_shift <= {al_shift[14:0], sr_in_sync[1]};
                    end else if (al_tick) begin
                        al_sk <= 1'b0;
                        al_cmd <= {al_cmd[RMAP_SR_CMD_BITS-2:0], 1'b0};
                        if (al_bit == 5'(RMAP_SR_CMD_BITS
                                         + RMAP_SR_DATA_BITS - 1)) begin
                            al_state <= AL_GAP;
                            al_cs <= 1'b0;
                            o_cfg_we <= 1'b1;
                            o_cfg_addr <= al_word;
                            o_cfg_data <= al_shift;
                        end else begin
                            al_bit <= al_bit + 5'h01;
                        end
                    end
                end
                AL_GAP: begin
                    if (al_tick) begin
                        if (al_word == RMAP_SR_ADDR_W'(LOAD_WORDS - 1)) begin
                            al_state <= AL_IDLE;
                            load_done <= 1'b1;
                            ev_load <= 1'b1;
                        end else begin
                            al_state <= AL_SHIFT;
                            al_word <= al_word + 1'b1;
                            al_cmd <= sr_cmd(al_word + 1'b1);
                            al_bit <= 5'h00;
                            al_cs <= 1'b1;
                        end
                    end
                end
                default: begin
                    al_state <= AL_IDLE;
                end
            endcase
        end
    end

    // Boot ROM or external register strobe of fixed length
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ma_state <= MA_IDLE;
            ma_cnt <= 8'h00;
            ev_rd <= 1'b0;
            ev_wr <= 1'b0;
        end else begin
            ev_rd <= 1'b0;
            ev_wr <= 1'b0;
            unique case (ma_state)
                MA_IDLE: begin
                    ma_cnt <= 8'(RMAP_ROM_ACC_CYC - 1);
                    // Serial ROM is bit-banged: trigger completes at once
                    if (srom_sel && (rd_trig || wr_trig)) begin
                        ev_rd <= rd_trig;
                        ev_wr <= wr_trig;
                    end else if (rd_trig) begin
                        ma_state <= MA_READ;
                    end else if (wr_trig) begin
                        ma_state <= MA_WRITE;
                    end
                end
                MA_READ, MA_WRITE: begin
                    ma_cnt <= ma_cnt - 8'h01;
                    if (ma_cnt == 8'h00) begin
                        ma_state <= MA_IDLE;
                        ev_rd <= (ma_state == MA_READ);
                        ev_wr <= (ma_state == MA_WRITE);
                    end
                end
                default: begin
                    ma_state <= MA_IDLE;
                end
            endcase
        end
    end

    // Registered pins; the autoload owns the serial ROM while it runs
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_srom <= '0;
            o_mgmt <= '0;
            o_rom <= '0;
            o_rom.rom_cs_n <= 1'b1;
            o_rom.xreg_cs_n <= 1'b1;
            o_rom.oe_n <= 1'b1;
            o_rom.we_n <= 1'b1;
        end else begin
            if (al_state != AL_IDLE) begin
                o_srom.cs <= al_cs;
                o_srom.clk <= al_sk;
                o_srom.dout <= al_cmd[RMAP_SR_CMD_BITS-1];
            end else if (srom_sel) begin
                o_srom.cs <= data[RMAP_B_SR_CS];
                o_srom.clk <= data[RMAP_B_SR_CLK];
                o_srom.dout <= data[RMAP_B_SR_SEND];
            end else begin
                o_srom <= '0;
            end
            // Pins follow the bits; no edge is timed here
            o_mgmt.clk <= md_clk;
            o_mgmt.dout <= md_out;
            o_mgmt.doe <= !md_dir;
            // Boot ROM wins when both parallel targets are selected
            o_rom.addr <= pointer;
            o_rom.dout <= data;
            o_rom.doe <= (ma_state == MA_WRITE);
            o_rom.rom_cs_n <= !(ma_state != MA_IDLE && brom_sel);
            o_rom.xreg_cs_n <= !((ma_state != MA_IDLE) && !brom_sel
                                 && xreg_sel);
            o_rom.oe_n <= !(ma_state == MA_READ);
            o_rom.we_n <= !(ma_state == MA_WRITE);
        end
    end

endmodule

//--- shared/rmap_pkg.sv
// Constants and carrier types of the ROM and management access port
package rmap_pkg;
    // Register byte offsets
    localparam logic [7:0] RMAP_OFS_ACCESS = 8'h00;
    localparam logic [7:0] RMAP_OFS_POINTER = 8'h04;
    localparam logic [7:0] RMAP_OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] RMAP_OFS_IRQ_MASK = 8'h0c;
    // Access register field positions
    localparam int RMAP_B_LOAD_DONE = 21;
    localparam int RMAP_B_RELOAD = 20;
    localparam int RMAP_B_MD_IN = 19;
    localparam int RMAP_B_MD_DIR = 18;
    localparam int RMAP_B_MD_OUT = 17;
    localparam int RMAP_B_MD_CLK = 16;
    localparam int RMAP_B_ONE_HI = 15;
    localparam int RMAP_B_RD_TRIG = 14;
    localparam int RMAP_B_WR_TRIG = 13;
    localparam int RMAP_B_BROM_SEL = 12;
    localparam int RMAP_B_SROM_SEL = 11;
    localparam int RMAP_B_XREG_SEL = 10;
    localparam int RMAP_B_ONE_LO = 8;
    localparam int RMAP_B_SR_RET = 3;
    localparam int RMAP_B_SR_SEND = 2;
    localparam int RMAP_B_SR_CLK = 1;
    localparam int RMAP_B_SR_CS = 0;
    localparam int RMAP_PTR_W = 18;
    // Reset values of the control fields
    localparam logic RMAP_RST_BROM_SEL = 1'h1;
    localparam logic RMAP_RST_SROM_SEL = 1'h0;
    localparam logic RMAP_RST_XREG_SEL = 1'h1;
    localparam logic [7:0] RMAP_RST_DATA = 8'hff;
    // Interrupt status bits
    localparam int RMAP_EV_LOAD = 0;
    localparam int RMAP_EV_RD = 1;
    localparam int RMAP_EV_WR = 2;
    localparam int RMAP_EV_W = 3;
    // Serial ROM load frame: start, read opcode, address, data
    localparam logic [2:0] RMAP_SR_READ_OP = 3'h6;
    localparam int RMAP_SR_ADDR_W = 6;
    localparam int RMAP_SR_CMD_BITS = 9;
    localparam int RMAP_SR_DATA_BITS = 16;
    // Timing
    localparam int RMAP_CLK_NS = 50;
    localparam int RMAP_SR_HALF_NS = 1000;
    localparam int RMAP_ROM_ACC_NS = 250;
    localparam int RMAP_SR_HALF_CYC =
        (RMAP_SR_HALF_NS + RMAP_CLK_NS - 1) / RMAP_CLK_NS;
    localparam int RMAP_ROM_ACC_CYC =
        (RMAP_ROM_ACC_NS + RMAP_CLK_NS - 1) / RMAP_CLK_NS;

    // Serial ROM pins
    typedef struct packed {
        logic cs;
        logic clk;
        logic dout;
    } rmap_srom_t;

    // Parallel boot ROM bus
    typedef struct packed {
        logic [RMAP_PTR_W-1:0] addr;
        logic [7:0] dout;
        logic doe;
        logic rom_cs_n;
        logic xreg_cs_n;
        logic oe_n;
        logic we_n;
    } rmap_rom_t;

    // Management pins
    typedef struct packed {
        logic clk;
        logic dout;
        logic doe;
    } rmap_mgmt_t;
endpackage

//--- bench/rmap_port_monitor.sv
// Checker of bus, pin and strobe timing
`timescale 1ns/1ps
module rmap_port_monitor import rmap_pkg::*; #(
    parameter int LOAD_WORDS = 8
) (
    // Clock, reset and bus
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    // Pins
    input rmap_mgmt_t o_mgmt,
    input rmap_rom_t o_rom,
    input wire logic o_cfg_we
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    logic take, wr_q, wr_done;
    logic [7:0] wa_q, wa_d;
    logic [31:0] wd_q;
    assign take = i_hsel && i_htrans[1] && i_hready;
    // Track a write to one cycle past its data
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= 1'b0;
            wr_done <= 1'b0;
        end else begin
            wr_q <= take && i_hwrite;
            wr_done <= wr_q;
        end
    end
    // No reset needed: read only behind the flags
    always_ff @(posedge i_mclk) begin
        if (take) wa_q <= i_haddr[7:0];
        if (wr_q) wa_d <= wa_q;
        if (wr_q) wd_q <= i_hwdata;
    end
    sequence s_acc_wr;
        wr_done && wa_d == RMAP_OFS_ACCESS;
    endsequence
    sequence s_rd_strobe;
        (!o_rom.oe_n)[*5] ##1 o_rom.oe_n;
    endsequence
    sequence s_wr_strobe;
        (!o_rom.we_n && o_rom.doe)[*5] ##1 o_rom.we_n;
    endsequence
    property p_ready_wait;
        take |=> !o_hreadyout ##1 o_hreadyout;
    endproperty
    property p_md_dir;
        s_acc_wr |=> o_mgmt.doe == !wd_q[RMAP_B_MD_DIR];
    endproperty
    property p_md_out;
        s_acc_wr |=> o_mgmt.dout == wd_q[RMAP_B_MD_OUT];
    endproperty
    property p_md_clk;
        s_acc_wr |=> o_mgmt.clk == wd_q[RMAP_B_MD_CLK];
    endproperty
    property p_rd_strobe;
        $fell(o_rom.oe_n) |-> s_rd_strobe;
    endproperty
    property p_wr_strobe;
        $fell(o_rom.we_n) |-> s_wr_strobe;
    endproperty
    property p_brom_wins;
        $fell(o_rom.rom_cs_n) |-> o_rom.xreg_cs_n;
    endproperty
    property p_xreg_only;
        $fell(o_rom.xreg_cs_n) |-> o_rom.rom_cs_n;
    endproperty
    property p_ptr;
        wr_done && wa_d == RMAP_OFS_POINTER |=> o_rom.addr == wd_q[17:0];
    endproperty
    property p_cfg_pulse;
        o_cfg_we |=> !o_cfg_we;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("wait state wrong");
    a_md_dir: assert property (p_md_dir)
        else $error("data enable wrong");
    a_md_out: assert property (p_md_out)
        else $error("data pin wrong");
    a_md_clk: assert property (p_md_clk)
        else $error("clock pin wrong");
    a_rd_strobe: assert property (p_rd_strobe)
        else $error("read strobe wrong");
    a_wr_strobe: assert property (p_wr_strobe)
        else $error("write strobe wrong");
    a_brom_wins: assert property (p_brom_wins)
        else $error("both selects low");
    a_xreg_only: assert property (p_xreg_only)
        else $error("both selects low");
    a_ptr: assert property (p_ptr)
        else $error("address wrong");
    a_cfg_pulse: assert property (p_cfg_pulse)
        else $error("word strobe too long");
endmodule

bind rmap_port rmap_port_monitor #(.LOAD_WORDS(LOAD_WORDS))
        u_rmap_port_monitor (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
    .o_mgmt(o_mgmt), .o_rom(o_rom), .o_cfg_we(o_cfg_we)
);

//--- bench/rmap_far_model.sv
// Far side: serial ROM, boot ROM and PHY management data line
`timescale 1ns/1ps
module rmap_far_model import rmap_pkg::*; (
    // Clock
    input wire logic i_mclk,
    // Pins from the port
    input rmap_srom_t i_srom,
    input rmap_rom_t i_rom,
    input rmap_mgmt_t i_mgmt,
    // Levels set by the bench
    input wire logic i_sr_val,
    input wire logic i_phy_val,
    // Pins toward the port
    output logic o_sr_pin,
    output logic [7:0] o_rom_data,
    output logic o_mgmt_pin
);
    logic clk_q = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [15:0] word;
    int n = 0;
    initial o_sr_pin = 1'b0;
    initial o_rom_data = 8'h00;
    assign word = {4'h9, adr, ~adr};
    // PHY drives the line once the port releases it
    assign o_mgmt_pin = i_mgmt.doe ? i_mgmt.dout : i_phy_val;
    // Serial ROM follows any edges it gets
    always @(posedge i_mclk) begin
        clk_q <= i_srom.clk;
        if (!i_srom.cs) begin
            n <= 0;
            o_sr_pin <= ~o_sr_pin; // Deselected: never a stable level
        end else if (i_srom.clk && !clk_q) begin
            if (n >= 3 && n <= 8) adr <= {adr[4:0], i_srom.dout};
            n <= n + 1;
        end else if (!i_srom.clk && clk_q && n >= 9 && n <= 24) begin
            o_sr_pin <= word[24-n];
        end else if (n == 0) begin
            o_sr_pin <= i_sr_val;
        end
    end
    // Released bus flips so stale data cannot match
    always @(posedge i_mclk) begin
        if (!i_rom.rom_cs_n && !i_rom.oe_n)
            o_rom_data <= i_rom.addr[7:0] ^ 8'h5a;
        else
            o_rom_data <= ~o_rom_data;
    end
endmodule

//--- bench/rmap_port_bench.sv
// Register-level bench of the ROM and management access port
`timescale 1ns/1ps
module rmap_port_bench import rmap_pkg::*;;
    localparam int NW = 2;
    localparam logic [31:0] SEL = 32'h0000_14ff;
    logic mclk = 1'b0, rst_n = 1'b0, hwrite = 1'b0;
    logic sr_val = 1'b0, phy_val = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic hready, hresp, irq, sr_pin, mgmt_pin, cfg_we;
    logic [7:0] rom_data;
    logic [5:0] cfg_addr;
    logic [15:0] cfg_data;
    rmap_srom_t srom;
    rmap_mgmt_t mgmt;
    rmap_rom_t rom;
    int err_total = 0, n_checks = 0, cyc = 0;
    always #25 mclk = ~mclk;
    rmap_port #(.LOAD_WORDS(NW)) u_rmap_port (
        .i_mclk(mclk), .i_rst_n(rst_n), .i_hsel(1'b1), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .o_irq(irq),
        .i_serial_rom_in_pin(sr_pin), .o_srom(srom),
        .i_mgmt_data_pin(mgmt_pin), .o_mgmt(mgmt), .i_rom_data(rom_data),
        .o_rom(rom), .o_cfg_we(cfg_we), .o_cfg_addr(cfg_addr),
        .o_cfg_data(cfg_data)
    );
    rmap_far_model u_rmap_far_model (
        .i_mclk(mclk), .i_srom(srom), .i_rom(rom), .i_mgmt(mgmt),
        .i_sr_val(sr_val), .i_phy_val(phy_val), .o_sr_pin(sr_pin),
        .o_rom_data(rom_data), .o_mgmt_pin(mgmt_pin)
    );
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Ceiling for every wait below
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic poll(input int b, input logic v);
        do bus(1'b0, RMAP_OFS_ACCESS, 32'h0); while (rd[b] !== v);
    endtask
    // Check each loaded word against the model
    task automatic load();
        logic [5:0] a;
        for (int k = 0; k < NW; k++) begin
            do @(posedge mclk); while (cfg_we !== 1'b1);
            a = 6'(k);
            chk(cfg_addr, k);
            chk(cfg_data, {4'h9, a, ~a});
        end
        poll(21, 1'b1);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        load();
        rdchk(RMAP_OFS_ACCESS, 32'hffff_ffff, 32'h0020_97ff);
        rdchk(RMAP_OFS_IRQ_STAT, 32'hf, 32'h1);
        chk(irq, 32'h0);
        wr(RMAP_OFS_IRQ_MASK, 32'h1);
        @(posedge mclk);
        chk(irq, 32'h1);
        wr(RMAP_OFS_IRQ_STAT, 32'h1);
        @(posedge mclk);
        chk(irq, 32'h0);
        // Management line released, then driven
        phy_val <= 1'b1;
        wr(RMAP_OFS_ACCESS, SEL | 32'h0004_0000);
        repeat (3) @(posedge mclk);
        chk(mgmt.doe, 32'h0);
        rdchk(RMAP_OFS_ACCESS, 32'h0008_0000, 32'h0008_0000);
        phy_val <= 1'b0;
        wr(RMAP_OFS_ACCESS, SEL | 32'h0003_0000);
        @(posedge mclk);
        chk(mgmt, 32'h7);
        // Boot ROM read, write, then an external register read
        wr(RMAP_OFS_POINTER, 32'h0002_a5c3);
        rdchk(RMAP_OFS_POINTER, 32'h3_ffff, 32'h2_a5c3);
        chk(rom.addr, 32'h2_a5c3);
        wr(RMAP_OFS_ACCESS, SEL | 32'h4000);
        poll(14, 1'b0);
        rdchk(RMAP_OFS_ACCESS, 32'hff, 32'h99);
        wr(RMAP_OFS_ACCESS, 32'h0000_346e);
        poll(13, 1'b0);
        chk(rom.dout, 32'h6e);
        wr(RMAP_OFS_ACCESS, 32'h0000_44ff);
        poll(14, 1'b0);
        rdchk(RMAP_OFS_IRQ_STAT, 32'h7, 32'h6);
        // Serial ROM pins by hand
        sr_val <= 1'b1;
        wr(RMAP_OFS_ACCESS, 32'h0000_0805);
        @(posedge mclk);
        chk(srom, 32'h5);
        repeat (3) @(posedge mclk);
        rdchk(RMAP_OFS_ACCESS, 32'h8, 32'h8);
        sr_val <= 1'b0;
        repeat (4) @(posedge mclk);
        rdchk(RMAP_OFS_ACCESS, 32'h8, 32'h0);
        wr(RMAP_OFS_ACCESS, 32'h0000_0806);
        @(posedge mclk);
        chk(srom, 32'h3);
        // Reload clears done and reruns the load
        wr(RMAP_OFS_ACCESS, SEL | 32'h0010_0000);
        rdchk(RMAP_OFS_ACCESS, 32'h0020_0000, 32'h0);
        load();
        rdchk(8'h10, 32'hffff_ffff, 32'h0);
        chk(hresp, 32'h0);
        final_report();
    end
endmodule
